// [inc/irq_xfer_pkg.sv]
`default_nettype none
package irq_xfer_pkg;
	// Node population: capture/compare nodes first, then the fast external inputs
	localparam int CC_LO_NODES = 16;
	localparam int CC_NODES = 29;
	localparam int EXT_NODES = 8;
	localparam int NODES = 37;
	localparam int CHANNELS = 8;
	localparam int RESP_CYCLES = 8;

	localparam logic [6:0] TRAP_CC_LO_BASE = 7'h10;
	localparam logic [6:0] TRAP_CC_HI_BASE = 7'h30;
	localparam logic [6:0] TRAP_EXT_BASE = 7'h40;
	localparam logic [3:0] TRAP_LEVEL = 4'hf;

	// Register map, word addresses
	localparam logic [7:0] A_CHAN_BASE = 8'h40;
	localparam logic [7:0] A_CHAN_END = 8'h60;
	localparam logic [7:0] A_STATUS = 8'h60;
	localparam logic [7:0] A_MASK = 8'h61;
	localparam logic [7:0] A_EDGE = 8'h62;
	localparam logic [1:0] CH_CTRL = 2'h0;
	localparam logic [1:0] CH_SRC = 2'h1;
	localparam logic [1:0] CH_DST = 2'h2;

	// Node control fields
	localparam int NC_LVL_LSB = 0;
	localparam int NC_EN = 6;
	localparam int NC_REQ = 7;
	localparam int NC_XSEL = 8;
	localparam int NC_CH_LSB = 9;

	// Channel control fields
	localparam int CC_CNT_LSB = 0;
	localparam int CC_WORD = 8;
	localparam int CC_ISRC = 9;
	localparam int CC_IDST = 10;
	localparam int CC_CONT = 11;

	// Status and mask layout: transfer-count-zero per channel, then edge per input
	localparam int ST_TC_LSB = 0;
	localparam int ST_EDGE_LSB = 8;

	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;

	typedef enum logic [1:0] {
		EDGE_OFF,
		EDGE_RISE,
		EDGE_FALL,
		EDGE_BOTH
	} edge_mode_t;
endpackage
`default_nettype wire

// [logic/ext_edge_detect.sv]
`default_nettype none
module ext_edge_detect (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Pin and edge selection
	input wire logic pin,
	input wire irq_xfer_pkg::edge_mode_t mode,
	// Detected edge
	output logic edge_pulse
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic stable;
		logic pulse;
	} state_t;

	state_t q;
	state_t d;

	always_comb begin
		d = q;
		d.s1 = pin;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.pulse = 1'b0;
		// A level counts only once two late stages agree
		if (q.s2 == q.s3 && q.s3 != q.stable) begin
			d.stable = q.s3;
			unique case (mode)
				irq_xfer_pkg::EDGE_OFF: d.pulse = 1'b0;
				irq_xfer_pkg::EDGE_RISE: d.pulse = q.s3;
				irq_xfer_pkg::EDGE_FALL: d.pulse = !q.s3;
				irq_xfer_pkg::EDGE_BOTH: d.pulse = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign edge_pulse = q.pulse;

	chk_edge_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(q.s2 && q.s3 && !q.stable && mode == irq_xfer_pkg::EDGE_RISE) |=> edge_pulse)
		else $error("rising edge not reported");
endmodule
`default_nettype wire

// [logic/irq_xfer_ctrl.sv]
// Decided for this implementation: the register offsets and the address-and-strobe port.
`default_nettype none
// What this block does
// - Vectored answer within eight clocks
// - Per node: vectored or transfer engine
// - Transfer takes one cycle, no branch
// - Move byte/word, bump chosen pointers
// - Count down per service unless continuous
// - Count at zero raises vectored interrupt
// - Eight independent transfer channels
// - Node register: request, enable, level
// - Sixteen priority levels per node
// - Only strictly higher level preempts, traps excepted
// - Each node owns its vector
// - External inputs: rising, falling, both edges
// - Trap number invokes its service
// - Software may set any request bit
// - Vector is four times trap number
module irq_xfer_ctrl (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Requesters
	input wire logic [irq_xfer_pkg::CC_NODES-1:0] periph_req,
	input wire logic [irq_xfer_pkg::EXT_NODES-1:0] fast_ext_irq_input,
	input wire logic trap_req,
	input wire logic [6:0] trap_num,
	// Core side
	input wire logic [3:0] cpu_level,
	input wire logic cpu_ack,
	output logic irq_req,
	output logic [15:0] irq_vector,
	output logic [3:0] irq_level,
	output logic xfer_req,
	output logic [15:0] xfer_src,
	output logic [15:0] xfer_dst,
	output logic xfer_word,
	// Event interrupt
	output logic event_irq
);
	localparam int NN = irq_xfer_pkg::NODES;
	localparam int NC = irq_xfer_pkg::CHANNELS;
	localparam int NE = irq_xfer_pkg::EXT_NODES;
	localparam int RESP_MAX = irq_xfer_pkg::RESP_CYCLES;

	typedef struct packed {
		logic [NN-1:0] req;
		logic [NN-1:0] en;
		logic [NN-1:0] xsel;
		logic [NN-1:0][3:0] lvl;
		logic [NN-1:0][2:0] ch;
		logic [NC-1:0][7:0] cnt;
		logic [NC-1:0] word;
		logic [NC-1:0] isrc;
		logic [NC-1:0] idst;
		logic [NC-1:0] cont;
		logic [NC-1:0][15:0] src;
		logic [NC-1:0][15:0] dst;
		logic [15:0] status;
		logic [15:0] mask;
		logic [15:0] edge_sel;
		logic [15:0] rdata;
		logic irq_req;
		logic irq_trap;
		logic [5:0] irq_node;
		logic [15:0] irq_vec;
		logic [3:0] irq_lvl;
		logic trap_pend;
		logic [6:0] trap_no;
		logic xfer_req;
		logic [15:0] xfer_src;
		logic [15:0] xfer_dst;
		logic xfer_word;
		logic event_irq;
	} state_t;

	state_t q;
	state_t d;

	logic [NE-1:0] ext_pulse;
	logic win_ok;
	logic [5:0] win_node;
	logic [3:0] win_lvl;
	logic [2:0] win_ch;
	logic pec_ok;
	logic pec_go;
	logic vect_win;
	logic [15:0] win_step;

	// one synchronising edge detector per fast input
	for (genvar i = 0; i < NE; i++) begin : g_ext
		ext_edge_detect u_edge (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.pin(fast_ext_irq_input[i]),
			.mode(irq_xfer_pkg::edge_mode_t'(q.edge_sel[2*i +: 2])),
			.edge_pulse(ext_pulse[i])
		);
	end

	function automatic logic [6:0] node_trap(input logic [5:0] n);
		if (n < 6'(irq_xfer_pkg::CC_LO_NODES)) begin
			return irq_xfer_pkg::TRAP_CC_LO_BASE + 7'(n);
		end else if (n < 6'(irq_xfer_pkg::CC_NODES)) begin
			return irq_xfer_pkg::TRAP_CC_HI_BASE + 7'(n - 6'(irq_xfer_pkg::CC_LO_NODES));
		end
		return irq_xfer_pkg::TRAP_EXT_BASE + 7'(n - 6'(irq_xfer_pkg::CC_NODES));
	endfunction

	function automatic logic [15:0] trap_vector(input logic [6:0] t);
		return {7'h00, t, 2'b00};
	endfunction

	// priority search; strict compare keeps the lowest node on a tie
	always_comb begin
		win_ok = 1'b0;
		win_node = 6'h00;
		win_lvl = 4'h0;
		for (int n = 0; n < NN; n++) begin
			// only levels above the running service compete
			if (q.req[n] && q.en[n] && q.lvl[n] > cpu_level && (!win_ok || q.lvl[n] > win_lvl)) begin
				win_ok = 1'b1;
				win_node = 6'(n);
				win_lvl = q.lvl[n];
			end
		end
	end

	assign win_ch = q.ch[win_node];
	// an exhausted channel falls back to the vectored path
	assign pec_ok = q.xsel[win_node] && (q.cont[win_ch] || q.cnt[win_ch] != 8'h00);
	assign pec_go = win_ok && pec_ok;
	assign vect_win = win_ok && !pec_ok;
	assign win_step = q.word[win_ch] ? irq_xfer_pkg::STEP_WORD : irq_xfer_pkg::STEP_BYTE;

	always_comb begin
		logic [5:0] idx;
		logic [2:0] c;
		logic [15:0] w1c;
		logic [15:0] events;
		idx = reg_addr[5:0];
		c = reg_addr[4:2];
		w1c = 16'h0000;
		events = 16'h0000;
		d = q;
		d.rdata = 16'h0000;
		d.xfer_req = 1'b0;

		// Acknowledge first, so a software set in the same cycle survives
		if (cpu_ack && q.irq_req) begin
			if (q.irq_trap) begin
				d.trap_pend = 1'b0;
			end else begin
				d.req[q.irq_node] = 1'b0;
			end
		end

		// Register reads answer in the next cycle only
		if (reg_rd) begin
			if (reg_addr < 8'(NN)) begin
				// node control readback with live request flag
				d.rdata[irq_xfer_pkg::NC_LVL_LSB +: 4] = q.lvl[idx];
				d.rdata[irq_xfer_pkg::NC_EN] = q.en[idx];
				d.rdata[irq_xfer_pkg::NC_REQ] = q.req[idx];
				d.rdata[irq_xfer_pkg::NC_XSEL] = q.xsel[idx];
				d.rdata[irq_xfer_pkg::NC_CH_LSB +: 3] = q.ch[idx];
			end else if (reg_addr >= irq_xfer_pkg::A_CHAN_BASE && reg_addr < irq_xfer_pkg::A_CHAN_END) begin
				if (reg_addr[1:0] == irq_xfer_pkg::CH_CTRL) begin
					d.rdata[irq_xfer_pkg::CC_CNT_LSB +: 8] = q.cnt[c];
					d.rdata[irq_xfer_pkg::CC_WORD] = q.word[c];
					d.rdata[irq_xfer_pkg::CC_ISRC] = q.isrc[c];
					d.rdata[irq_xfer_pkg::CC_IDST] = q.idst[c];
					d.rdata[irq_xfer_pkg::CC_CONT] = q.cont[c];
				end else if (reg_addr[1:0] == irq_xfer_pkg::CH_SRC) begin
					d.rdata = q.src[c];
				end else if (reg_addr[1:0] == irq_xfer_pkg::CH_DST) begin
					d.rdata = q.dst[c];
				end
			end else if (reg_addr == irq_xfer_pkg::A_STATUS) begin
				d.rdata = q.status;
			end else if (reg_addr == irq_xfer_pkg::A_MASK) begin
				d.rdata = q.mask;
			end else if (reg_addr == irq_xfer_pkg::A_EDGE) begin
				d.rdata = q.edge_sel;
			end
		end

		if (reg_wr) begin
			if (reg_addr < 8'(NN)) begin
				// node setup; request bit is writable on every node
				d.lvl[idx] = reg_wdata[irq_xfer_pkg::NC_LVL_LSB +: 4];
				d.en[idx] = reg_wdata[irq_xfer_pkg::NC_EN];
				d.req[idx] = reg_wdata[irq_xfer_pkg::NC_REQ];
				d.xsel[idx] = reg_wdata[irq_xfer_pkg::NC_XSEL];
				d.ch[idx] = reg_wdata[irq_xfer_pkg::NC_CH_LSB +: 3];
			end else if (reg_addr >= irq_xfer_pkg::A_CHAN_BASE && reg_addr < irq_xfer_pkg::A_CHAN_END) begin
				if (reg_addr[1:0] == irq_xfer_pkg::CH_CTRL) begin
					d.cnt[c] = reg_wdata[irq_xfer_pkg::CC_CNT_LSB +: 8];
					d.word[c] = reg_wdata[irq_xfer_pkg::CC_WORD];
					d.isrc[c] = reg_wdata[irq_xfer_pkg::CC_ISRC];
					d.idst[c] = reg_wdata[irq_xfer_pkg::CC_IDST];
					d.cont[c] = reg_wdata[irq_xfer_pkg::CC_CONT];
				end else if (reg_addr[1:0] == irq_xfer_pkg::CH_SRC) begin
					d.src[c] = reg_wdata;
				end else if (reg_addr[1:0] == irq_xfer_pkg::CH_DST) begin
					d.dst[c] = reg_wdata;
				end
			end else if (reg_addr == irq_xfer_pkg::A_STATUS) begin
				w1c = reg_wdata;
			end else if (reg_addr == irq_xfer_pkg::A_MASK) begin
				d.mask = reg_wdata;
			end else if (reg_addr == irq_xfer_pkg::A_EDGE) begin
				d.edge_sel = reg_wdata;
			end
		end

		// a new trap is taken unless one is still waiting
		if (trap_req && (!q.trap_pend || (cpu_ack && q.irq_req && q.irq_trap))) begin
			d.trap_pend = 1'b1;
			d.trap_no = trap_num;
		end

		// one stolen cycle on the node's own channel
		if (pec_go) begin
			d.xfer_req = 1'b1;
			d.xfer_src = q.src[win_ch];
			d.xfer_dst = q.dst[win_ch];
			d.xfer_word = q.word[win_ch];
			// pointer increments by the moved size
			if (q.isrc[win_ch]) begin
				d.src[win_ch] = q.src[win_ch] + win_step;
			end
			if (q.idst[win_ch]) begin
				d.dst[win_ch] = q.dst[win_ch] + win_step;
			end
			if (!q.cont[win_ch]) begin
				d.cnt[win_ch] = q.cnt[win_ch] - 8'h01;
			end
			// last transfer leaves the request up for a vectored service
			d.req[win_node] = !q.cont[win_ch] && q.cnt[win_ch] == 8'h01;
			if (!q.cont[win_ch] && q.cnt[win_ch] == 8'h01) begin
				events[irq_xfer_pkg::ST_TC_LSB + 32'(win_ch)] = 1'b1;
			end
		end

		// Hardware requests applied last so a same-cycle clear never loses them
		d.req = d.req | {ext_pulse, periph_req};
		events[irq_xfer_pkg::ST_EDGE_LSB +: NE] = ext_pulse;
		d.status = (q.status & ~w1c) | events;
		d.event_irq = |(d.status & d.mask);

		// the winner is on the core port one clock after it wins
		if (cpu_ack && q.irq_req) begin
			d.irq_req = 1'b0;
		end else if (q.trap_pend) begin
			d.irq_req = 1'b1;
			d.irq_trap = 1'b1;
			d.irq_vec = trap_vector(q.trap_no);
			d.irq_lvl = irq_xfer_pkg::TRAP_LEVEL;
		end else if (vect_win) begin
			d.irq_req = 1'b1;
			d.irq_trap = 1'b0;
			d.irq_node = win_node;
			d.irq_vec = trap_vector(node_trap(win_node));
			d.irq_lvl = win_lvl;
		end else begin
			d.irq_req = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata = q.rdata;
	assign irq_req = q.irq_req;
	assign irq_vector = q.irq_vec;
	assign irq_level = q.irq_lvl;
	assign xfer_req = q.xfer_req;
	assign xfer_src = q.xfer_src;
	assign xfer_dst = q.xfer_dst;
	assign xfer_word = q.xfer_word;
	assign event_irq = q.event_irq;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	chk_resp_latency: assert property (
		(vect_win && !q.irq_req && !cpu_ack) |-> ##[1:RESP_MAX] irq_req)
		else $error("vectored request not presented in time");
	chk_pec_steal: assert property (
		(pec_go && !q.trap_pend && !vect_win) |=> xfer_req && (!irq_req || $past(q.irq_req)))
		else $error("transfer service did not take one plain cycle");
	chk_pointer_bump: assert property (
		(pec_go && q.isrc[win_ch]) |=>
		q.src[$past(win_ch)] == $past(q.src[win_ch]) + $past(win_step) && xfer_src == $past(q.src[win_ch]))
		else $error("source pointer not advanced");
	chk_count_down: assert property (
		(pec_go && !q.cont[win_ch]) |=> q.cnt[$past(win_ch)] == $past(q.cnt[win_ch]) - 8'h01)
		else $error("transfer count not decremented");
	chk_count_hold: assert property (
		(pec_go && q.cont[win_ch] && !reg_wr) |=> q.cnt[$past(win_ch)] == $past(q.cnt[win_ch]))
		else $error("continuous mode changed the count");
	chk_zero_vectors: assert property (
		(win_ok && q.xsel[win_node] && !q.cont[win_ch] && q.cnt[win_ch] == 8'h00 && !q.trap_pend
		&& !(cpu_ack && q.irq_req)) |=> irq_req && !xfer_req && irq_level == $past(win_lvl))
		else $error("exhausted channel still transferring");
	chk_strict_level: assert property (
		(irq_req && !q.irq_trap && !$past(cpu_ack)) |-> irq_level > $past(cpu_level))
		else $error("request shown at or below current level");
	chk_vector_map: assert property (
		(irq_req && !q.irq_trap) |-> irq_vector == trap_vector(node_trap(q.irq_node)))
		else $error("node vector mismatch");
	chk_trap_vector: assert property (
		(trap_req && !q.trap_pend && !q.irq_req) |-> ##2 irq_req && irq_vector == {7'h00, $past(trap_num, 2), 2'b00})
		else $error("trap vector not presented");
	chk_sw_request: assert property (
		(reg_wr && reg_addr < 8'(NN) && reg_wdata[irq_xfer_pkg::NC_REQ] && !pec_go) |=> q.req[$past(reg_addr[5:0])])
		else $error("software request bit not set");
	chk_event_line: assert property (
		(|(q.status & q.mask)) |-> event_irq)
		else $error("event interrupt low with unmasked status");

	cov_transfer: cover property (pec_go);
	cov_count_zero: cover property (pec_go ##1 vect_win ##[1:4] irq_req ##[1:8] cpu_ack);
	cov_trap_taken: cover property (irq_req && q.irq_trap && cpu_ack);
endmodule
`default_nettype wire

// [bench/core_model.sv]
`default_nettype none
module core_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Request from the controller
	input wire logic irq_req,
	input wire logic [15:0] irq_vector,
	input wire logic [3:0] irq_level,
	input wire logic slow,
	// Acceptance
	output logic cpu_ack,
	output logic [15:0] last_vec,
	output logic [3:0] last_lvl,
	output logic [7:0] n_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] wait_q;
	// A slow core lets the request stand, so a later winner may still replace it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cpu_ack <= 1'b0;
			wait_q <= 2'h0;
			last_vec <= 16'h0000;
			last_lvl <= 4'h0;
			n_ack <= 8'h00;
		end else if (cpu_ack) begin
			cpu_ack <= 1'b0;
			last_vec <= irq_vector;
			last_lvl <= irq_level;
			n_ack <= n_ack + 8'h01;
			wait_q <= 2'h0;
		end else if (irq_req) begin
			if (!slow || wait_q == 2'h3)
				cpu_ack <= 1'b1;
			wait_q <= wait_q + 2'h1;
		end
	end
endmodule
`default_nettype wire

// [bench/interrupt_and_event_transfer_tb_top.sv]
`default_nettype none
module interrupt_and_event_transfer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CN = irq_xfer_pkg::CC_NODES;
	logic clk_sys, rst_n, reg_wr, reg_rd, trap_req, cpu_ack, irq_req, xfer_req, xfer_word, event_irq, slow;
	logic [7:0] reg_addr, fast_pin, n_ack, n0;
	logic [15:0] reg_wdata, reg_rdata, irq_vector, xfer_src, xfer_dst, last_vec, rnd;
	logic [CN-1:0] periph_req;
	logic [6:0] trap_num;
	logic [3:0] cpu_level, irq_level, last_lvl, lv;
	int err_total, num_checks, cyc, n;

	irq_xfer_ctrl uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req),
		.fast_ext_irq_input(fast_pin), .trap_req(trap_req), .trap_num(trap_num), .cpu_level(cpu_level),
		.cpu_ack(cpu_ack), .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
		.xfer_req(xfer_req), .xfer_src(xfer_src), .xfer_dst(xfer_dst), .xfer_word(xfer_word),
		.event_irq(event_irq));
	core_model u_core (.clk_sys(clk_sys), .rst_n(rst_n), .irq_req(irq_req), .irq_vector(irq_vector),
		.irq_level(irq_level), .slow(slow), .cpu_ack(cpu_ack), .last_vec(last_vec), .last_lvl(last_lvl),
		.n_ack(n_ack));

	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [15:0] vec(input int k);
		logic [6:0] t;
		if (k < 16) t = 7'h10 + 7'(k);
		else if (k < 29) t = 7'h30 + 7'(k - 16);
		else t = irq_xfer_pkg::TRAP_EXT_BASE + 7'(k - 29);
		return {7'h00, t, 2'b00};
	endfunction
	task automatic wrap_up();
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc_n(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, v);
	endtask
	task automatic pulse(input int k);
		@(posedge clk_sys);
		periph_req <= {{(CN-1){1'b0}}, 1'b1} << k;
		@(posedge clk_sys);
		periph_req <= '0;
	endtask
	task automatic wait_irq();
		int k;
		k = 0;
		while (irq_req !== 1'b1 && k < 20) begin
			@(posedge clk_sys);
			#1 k++;
		end
		chk(48'(k <= irq_xfer_pkg::RESP_CYCLES), 48'h1);
	endtask
	task automatic wait_ack(input logic [15:0] ev, input logic [3:0] el);
		int k;
		k = 0;
		while (n_ack == n0 && k < 40) begin
			@(posedge clk_sys);
			k++;
		end
		#1 chk({last_lvl, last_vec}, {el, ev});
		chk(48'(k < 40), 48'h1);
		n0 = n_ack;
	endtask
	task automatic wait_xfer(input logic [15:0] es, input logic [15:0] ed, input logic ew);
		int k;
		k = 0;
		while (xfer_req !== 1'b1 && k < 20) begin
			@(posedge clk_sys);
			#1 k++;
		end
		chk({xfer_word, xfer_src, xfer_dst}, {ew, es, ed});
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Hang guard, far above the few hundred cycles the sequence needs
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			wrap_up();
		end
	end

	initial begin
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		periph_req = '0;
		fast_pin = 8'h00;
		trap_req = 1'b0;
		trap_num = 7'h00;
		cpu_level = 4'h0;
		slow = 1'b0;
		n0 = 8'h00;
		rnd = 16'h003a;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		cyc_n(4);
		rc(8'h03, 16'h0000);
		wr(8'h03, 16'h0145);
		rc(8'h03, 16'h0145);
		rc(8'h30, 16'h0000);
		wr(8'h03, 16'h0000);
		for (int c = 0; c < 8; c++) begin
			wr(8'(8'h41 + 4 * c), 16'(16'h1111 * c));
			rc(8'(8'h41 + 4 * c), 16'(16'h1111 * c));
		end
		for (int m = 0; m < 4; m++) begin
			wr(8'h62, 16'(m) << (2 * m));
			wr(8'h60, 16'hffff);
			fast_pin[m] <= 1'b1;
			cyc_n(8);
			rc(8'h60, 16'(m % 2) << (8 + m));
			wr(8'h60, 16'hffff);
			fast_pin[m] <= 1'b0;
			cyc_n(8);
			rc(8'h60, 16'(m >= 2) << (8 + m));
		end
		for (int i = 0; i < 12; i++) begin
			rnd = lfsr(rnd);
			n = int'(rnd[15:8]) % irq_xfer_pkg::NODES;
			lv = rnd[3:0] % 4'hf + 4'h1;
			slow <= rnd[4];
			wr(8'(n), {8'h00, 2'b11, 2'b00, lv});
			wait_irq();
			wait_ack(vec(n), lv);
			rc(8'(n), {8'h00, 2'b01, 2'b00, lv});
		end
		cpu_level <= 4'hf;
		wr(8'h09, 16'h00c7);
		wr(8'h05, 16'h00c3);
		wr(8'h02, 16'h00c6);
		wr(8'h04, 16'h00c6);
		cyc_n(10);
		chk(irq_req, 1'b0);
		trap_num <= 7'h25;
		trap_req <= 1'b1;
		@(posedge clk_sys);
		trap_req <= 1'b0;
		wait_ack(16'h0094, 4'hf);
		cpu_level <= 4'h6;
		wait_ack(16'h0064, 4'h7);
		cyc_n(10);
		chk(irq_req, 1'b0);
		cpu_level <= 4'h0;
		wait_ack(16'h0048, 4'h6);
		wait_ack(16'h0050, 4'h6);
		wait_ack(16'h0054, 4'h3);
		wr(8'h44, 16'h0702);
		wr(8'h45, 16'h0100);
		wr(8'h46, 16'h0200);
		wr(8'h61, 16'h0002);
		wr(8'h07, 16'h0344);
		pulse(7);
		wait_xfer(16'h0100, 16'h0200, 1'b1);
		cyc_n(4);
		chk(n_ack, n0);
		pulse(7);
		wait_xfer(16'h0102, 16'h0202, 1'b1);
		wait_ack(vec(7), 4'h4);
		rc(8'h44, 16'h0700);
		rc(8'h45, 16'h0104);
		rc(8'h46, 16'h0204);
		// Edge bit of input 3 is still set from the both-edges pass
		rc(8'h60, 16'h0802);
		chk(event_irq, 1'b1);
		wr(8'h61, 16'h0000);
		cyc_n(2);
		chk(event_irq, 1'b0);
		wr(8'h61, 16'h0002);
		cyc_n(2);
		chk(event_irq, 1'b1);
		wr(8'h60, 16'h0002);
		cyc_n(2);
		chk(event_irq, 1'b0);
		wr(8'h48, 16'h0a00);
		wr(8'h49, 16'h0300);
		wr(8'h4a, 16'h0400);
		wr(8'h08, 16'h0544);
		pulse(8);
		wait_xfer(16'h0300, 16'h0400, 1'b0);
		pulse(8);
		wait_xfer(16'h0301, 16'h0400, 1'b0);
		rc(8'h48, 16'h0a00);
		rc(8'h49, 16'h0302);
		rc(8'h4a, 16'h0400);
		chk(n_ack, n0);
		wrap_up();
	end
endmodule
`default_nettype wire
